//--- instr_exec.sv
/*
  Executor for an 8-bit core instruction subset: immediate OR and load into
  the accumulator, page register moves, data register store, long call and
  long jump. Assumes program memory presents one decoded word per cycle
  while instr_ready_o is high and holds it otherwise; page register read
  data arrives combinationally for the address on page_raddr_o.
*/
// Summary of operation
// - OR immediate into accumulator, update zero
// - Page register 5..15 to accumulator, flags kept
// - Accumulator to page register, one cycle
// - Long call pushes return, bumps pointer unless already at STACK_DEPTH, 2 cycles
// - Long jump loads all eleven counter bits
// - Immediate into accumulator, flags unchanged
// - Accumulator into data register 0..127
`timescale 1ns/1ps
`default_nettype none

module instr_exec
  import instr_exec_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = 8  // Call stack levels
)(
  input  wire logic                   mclk_i,        // Core clock, 40 MHz
  input  wire logic                   sys_rst_i,     // Synchronous reset
  input  wire logic                   instr_valid_i, // Instruction present
  input  wire instr_t                 instr_i,       // Decoded instruction
  output logic                        instr_ready_o, // Ready to take an instruction
  input  wire logic [DATA_W-1:0]      page_rdata_i,  // Page register data
  output logic [PAGE_ADDR_W-1:0]      page_raddr_o,  // Page read address
  output wr_req_t                     page_wr_o,     // Page register write
  output wr_req_t                     reg_wr_o,      // Data register write
  output push_req_t                   push_o,        // Stack push
  output logic [DATA_W-1:0]           acc_o,         // Accumulator
  output logic                        zero_o,        // Zero flag
  output logic [PC_W-1:0]             pc_o,          // Program counter
  output logic [SP_W-1:0]             sp_o,          // Stack pointer
  output logic                        stack_ovf_o    // Push past depth seen
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (STACK_DEPTH < 1 || STACK_DEPTH > (1 << SP_W) - 1)
  begin : g_bad_depth
    $error("STACK_DEPTH out of range for the stack pointer width");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  state_t               state_r, state_nxt;    // Call sequencing
  logic [DATA_W-1:0]    acc_r, acc_nxt;        // Accumulator
  logic                 zero_r, zero_nxt;      // Zero flag
  logic [PC_W-1:0]      pc_r, pc_nxt;          // Program counter
  logic [SP_W-1:0]      sp_r, sp_nxt;          // Stack pointer
  logic                 ovf_r, ovf_nxt;        // Sticky stack overflow
  logic [PC_W-1:0]      tgt_r, tgt_nxt;        // Call target held for cycle 2
  wr_req_t              page_wr_r, page_wr_nxt; // Registered page write
  wr_req_t              reg_wr_r, reg_wr_nxt;  // Registered data write
  push_req_t            push_r, push_nxt;      // Registered push
  logic                 take;                  // Instruction accepted now
  logic                 page_ok;               // Page address in 5..15
  logic [DATA_W-1:0]    or_res;                // OR result

  // Stall intake during the second call cycle, that keeps the call 2 cycles
  assign instr_ready_o = (state_r == ST_RUN);
  assign take          = instr_valid_i && instr_ready_o;
  assign page_raddr_o  = instr_i.reg_a[PAGE_ADDR_W-1:0];
  assign page_ok       = (instr_i.reg_a[REG_ADDR_W-1:PAGE_ADDR_W] == '0) &&
                         (instr_i.reg_a[PAGE_ADDR_W-1:0] >= PAGE_MIN) &&
                         (instr_i.reg_a[PAGE_ADDR_W-1:0] <= PAGE_MAX);
  assign or_res        = acc_r | instr_i.imm;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Every instruction computes its effect in the cycle it is taken, except the long call, whose target is loaded in cycle 2
  always_comb
  begin
    state_nxt   = state_r;
    acc_nxt     = acc_r;
    zero_nxt    = zero_r;
    pc_nxt      = pc_r;
    sp_nxt      = sp_r;
    ovf_nxt     = ovf_r;
    tgt_nxt     = tgt_r;
    page_wr_nxt = '0;
    reg_wr_nxt  = '0;
    push_nxt    = '0;
    unique case (state_r)
      ST_RUN:
      begin
        if (take)
        begin
          // Default sequential flow
          pc_nxt = PC_W'(pc_r + 1'b1);
          unique case (instr_i.op)
            OP_OR_IMMEDIATE_ACC:
            begin
              acc_nxt  = or_res;
              zero_nxt = (or_res == '0);
            end
            OP_READ_PAGE_REG_TO_ACC:
            begin
              // Out-of-page addresses are ignored rather than guessed at
              if (page_ok)
              begin
                acc_nxt = page_rdata_i;
              end
            end
            OP_WRITE_PAGE_REG_FROM_ACC:
            begin
              if (page_ok)
              begin
                page_wr_nxt.we   = 1'b1;
                page_wr_nxt.addr = instr_i.reg_a;
                page_wr_nxt.data = acc_r;
              end
            end
            OP_LONG_CALL:
            begin
              // Push return address now, land on target after cycle 2
              push_nxt.push = 1'b1;
              push_nxt.slot = sp_r;
              push_nxt.ret  = PC_W'(pc_r + 1'b1);
              if (sp_r == SP_W'(STACK_DEPTH))
              begin
                // Pointer saturates; overflow recorded for the core
                ovf_nxt = 1'b1;
              end
              else
              begin
                sp_nxt = SP_W'(sp_r + 1'b1);
              end
              tgt_nxt   = instr_i.addr;
              state_nxt = ST_CALL2;
            end
            OP_LONG_JUMP:
            begin
              pc_nxt = instr_i.addr;
            end
            OP_LOAD_IMMEDIATE_ACC:
            begin
              acc_nxt = instr_i.imm;
            end
            OP_STORE_ACC_TO_REG:
            begin
              reg_wr_nxt.we   = 1'b1;
              reg_wr_nxt.addr = instr_i.reg_a;
              reg_wr_nxt.data = acc_r;
            end
            OP_NONE:
            begin
              // Plain advance
            end
          endcase
        end
      end
      ST_CALL2:
      begin
        pc_nxt    = tgt_r;
        state_nxt = ST_RUN;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Only registers the computed values
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state_r   <= ST_RUN;
      acc_r     <= ACC_RST;
      zero_r    <= ZERO_RST;
      pc_r      <= PC_RST;
      sp_r      <= SP_RST;
      ovf_r     <= 1'b0;
      tgt_r     <= PC_RST;
      page_wr_r <= '0;
      reg_wr_r  <= '0;
      push_r    <= '0;
    end
    else
    begin
      state_r   <= state_nxt;
      acc_r     <= acc_nxt;
      zero_r    <= zero_nxt;
      pc_r      <= pc_nxt;
      sp_r      <= sp_nxt;
      ovf_r     <= ovf_nxt;
      tgt_r     <= tgt_nxt;
      page_wr_r <= page_wr_nxt;
      reg_wr_r  <= reg_wr_nxt;
      push_r    <= push_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign acc_o       = acc_r;
  assign zero_o      = zero_r;
  assign pc_o        = pc_r;
  assign sp_o        = sp_r;
  assign stack_ovf_o = ovf_r;
  assign page_wr_o   = page_wr_r;
  assign reg_wr_o    = reg_wr_r;
  assign push_o      = push_r;

endmodule

`default_nettype wire

//--- instr_exec_chk.sv
/* Port checker for instr_exec, bound into every instance of it.
   Assumes one core clock and the synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module instr_exec_chk
  import instr_exec_pkg::*;
#(parameter int unsigned STACK_DEPTH = 8)(
  input wire logic              mclk_i,
  input wire logic              sys_rst_i,
  input wire logic              instr_valid_i,
  input wire instr_t            instr_i,
  input wire logic              instr_ready_o,
  input wire logic [DATA_W-1:0] page_rdata_i,
  input wire wr_req_t           page_wr_o,
  input wire wr_req_t           reg_wr_o,
  input wire push_req_t         push_o,
  input wire logic [DATA_W-1:0] acc_o,
  input wire logic              zero_o,
  input wire logic [PC_W-1:0]   pc_o,
  input wire logic [SP_W-1:0]   sp_o
);
  // ==========================================================================
  // Helpers: word taken, page address legal
  wire logic tk = instr_valid_i && instr_ready_o;
  wire logic pg = (instr_i.reg_a >= 7'h05) && (instr_i.reg_a <= 7'h0F);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // First call cycle pushes and stalls, second lands on the target
  sequence seq_call_push;
    push_o.push && push_o.slot == $past(sp_o) && sp_o == 4'($past(sp_o) + 1)
    && push_o.ret == 11'($past(pc_o) + 1) && !instr_ready_o;
  endsequence
  sequence seq_call_land;
    instr_ready_o && pc_o == $past(instr_i.addr, 2);
  endsequence
  chk_or_result: assert property (tk && instr_i.op == OP_OR_IMMEDIATE_ACC
    |=> acc_o == ($past(acc_o) | $past(instr_i.imm))) else $error("or result wrong");
  chk_zero_flag: assert property (tk && instr_i.op == OP_OR_IMMEDIATE_ACC
    |=> zero_o == (($past(acc_o) | $past(instr_i.imm)) == 8'h00)) else $error("zero flag wrong");
  chk_page_read: assert property (tk && pg && instr_i.op == OP_READ_PAGE_REG_TO_ACC
    |=> acc_o == $past(page_rdata_i) && $stable(zero_o)) else $error("page read wrong");
  chk_page_write: assert property (tk && pg && instr_i.op == OP_WRITE_PAGE_REG_FROM_ACC
    |=> page_wr_o.we && page_wr_o.addr == $past(instr_i.reg_a) && page_wr_o.data == $past(acc_o)
    && $stable(acc_o)) else $error("page write");
  // Page moves outside 5..15 must leave the accumulator and the page alone
  chk_page_refuse: assert property (tk && !pg &&
    instr_i.op inside {OP_READ_PAGE_REG_TO_ACC, OP_WRITE_PAGE_REG_FROM_ACC}
    |=> $stable(acc_o) && !page_wr_o.we) else $error("page refuse wrong");
  chk_call_steps: assert property (tk && instr_i.op == OP_LONG_CALL && sp_o < STACK_DEPTH
    |=> seq_call_push ##1 seq_call_land) else $error("call sequence wrong");
  chk_jump_target: assert property (tk && instr_i.op == OP_LONG_JUMP
    |=> pc_o == $past(instr_i.addr) && $stable(sp_o) && !push_o.push
    && $stable(zero_o)) else $error("jump wrong");
  chk_load_imm: assert property (tk && instr_i.op == OP_LOAD_IMMEDIATE_ACC
    |=> acc_o == $past(instr_i.imm) && $stable(zero_o)) else $error("load wrong");
  chk_store_reg: assert property (tk && instr_i.op == OP_STORE_ACC_TO_REG
    |=> reg_wr_o.we && reg_wr_o.addr == $past(instr_i.reg_a) && reg_wr_o.data == $past(acc_o)
    && $stable(acc_o) && $stable(zero_o)) else $error("store wrong");
endmodule
bind instr_exec instr_exec_chk #(.STACK_DEPTH(STACK_DEPTH)) u_instr_exec_chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .instr_ready_o(instr_ready_o), .page_rdata_i(page_rdata_i),
  .page_wr_o(page_wr_o), .reg_wr_o(reg_wr_o), .push_o(push_o), .acc_o(acc_o),
  .zero_o(zero_o), .pc_o(pc_o), .sp_o(sp_o));
`default_nettype wire

//--- instr_exec_pkg.sv
/*
  Constants, opcode enumeration and carrier structs for the instruction
  subset executor. Assumes a core that supplies decoded instruction words.
*/
`default_nettype none

package instr_exec_pkg;

  // ==========================================================================
  // Widths and ranges
  // ==========================================================================
  localparam int unsigned DATA_W       = 8;     // Accumulator and data width
  localparam int unsigned PC_W         = 11;    // Full program counter width
  localparam int unsigned REG_ADDR_W   = 7;     // Data register address width
  localparam int unsigned PAGE_ADDR_W  = 4;     // Special register page address
  localparam int unsigned SP_W         = 4;     // Stack pointer width
  localparam logic [3:0]  PAGE_MIN     = 4'h5;  // Lowest page register
  localparam logic [3:0]  PAGE_MAX     = 4'hF;  // Highest page register
  localparam logic [7:0]  ACC_RST      = 8'h00; // Accumulator after reset
  localparam logic [10:0] PC_RST       = 11'h000; // Program counter after reset
  localparam logic [3:0]  SP_RST       = 4'h0;  // Stack pointer after reset
  localparam logic        ZERO_RST     = 1'b0;  // Zero flag after reset
  localparam int unsigned CALL_CYCLES  = 2;     // Long call length in cycles

  // ==========================================================================
  // Operations handled by this block
  // ==========================================================================
  typedef enum logic [2:0] {
    OP_NONE                    = 3'h0,
    OP_OR_IMMEDIATE_ACC        = 3'h1,
    OP_READ_PAGE_REG_TO_ACC    = 3'h2,
    OP_WRITE_PAGE_REG_FROM_ACC = 3'h3,
    OP_LONG_CALL               = 3'h4,
    OP_LONG_JUMP               = 3'h5,
    OP_LOAD_IMMEDIATE_ACC      = 3'h6,
    OP_STORE_ACC_TO_REG        = 3'h7
  } op_t;

  // Decoded instruction as presented by program memory side
  typedef struct packed {
    op_t                    op;    // Operation
    logic [DATA_W-1:0]      imm;   // 8-bit immediate
    logic [PC_W-1:0]        addr;  // 11-bit branch target
    logic [REG_ADDR_W-1:0]  reg_a; // Register or page address
  } instr_t;

  // Register file / page write request
  typedef struct packed {
    logic                   we;    // Write strobe
    logic [REG_ADDR_W-1:0]  addr;  // Target address
    logic [DATA_W-1:0]      data;  // Write data
  } wr_req_t;

  // Stack push request
  typedef struct packed {
    logic                   push;  // Push strobe
    logic [SP_W-1:0]        slot;  // Slot written
    logic [PC_W-1:0]        ret;   // Return address
  } push_req_t;

  // Executor state, Gray along idle -> call second cycle
  typedef enum logic [0:0] {
    ST_RUN   = 1'b0,
    ST_CALL2 = 1'b1
  } state_t;

endpackage

`default_nettype wire

//--- page_reg_model.sv
/* Special register page model on the executor's far side.
   Assumes writes come as one-cycle strobes on the core clock. */
`timescale 1ns/1ps
`default_nettype none
module page_reg_model
  import instr_exec_pkg::*;
(
  input  wire logic                   mclk_i,       // Core clock
  input  wire logic [PAGE_ADDR_W-1:0] page_raddr_i, // Read address
  input  wire wr_req_t                page_wr_i,    // Write strobe
  output logic [DATA_W-1:0]           page_rdata_o  // Read data
);
  logic [DATA_W-1:0] bank_r [16];     // Page registers
  logic [DATA_W-1:0] last_r = 8'h3C;  // Last value shown
  // Holes below the page flip every cycle, so a stale read never looks clean
  always_comb
    page_rdata_o = (page_raddr_i >= PAGE_MIN) ? bank_r[page_raddr_i] : ~last_r;
  always_ff @(posedge mclk_i)
  begin
    last_r <= page_rdata_o;
    if (page_wr_i.we)
      bank_r[page_wr_i.addr[3:0]] <= page_wr_i.data;
  end
endmodule
`default_nettype wire

//--- tb_instr_exec.sv
/* Self-checking bench for instr_exec with the page register model.
   Assumes the checker is bound in; inputs move at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module tb_instr_exec
  import instr_exec_pkg::*;
;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, instr_valid_i = 1'b0, instr_ready_o, zero_o;
  instr_t            instr_i = '0;
  logic [7:0]        page_rdata_i, acc_o;
  logic [3:0]        page_raddr_o, sp_o;
  logic [10:0]       pc_o, exp_pc;
  wr_req_t           page_wr_o, reg_wr_o;
  push_req_t         push_o;
  logic              stack_ovf_o;
  int                errors = 0, samples_checked = 0;
  // Ordinary cases: op, imm, target, reg, expected acc and zero
  typedef struct {op_t op; logic [7:0] imm; logic [10:0] adr; logic [6:0] ra;
                  logic [7:0] acc; logic z;} row_t;
  row_t rows [14] = '{
    '{OP_OR_IMMEDIATE_ACC, 8'h00, 11'h000, 7'h00, 8'h00, 1'b1},
    '{OP_LOAD_IMMEDIATE_ACC, 8'hAA, 11'h000, 7'h00, 8'hAA, 1'b1},
    '{OP_WRITE_PAGE_REG_FROM_ACC, 8'h00, 11'h000, 7'h05, 8'hAA, 1'b1},
    '{OP_LOAD_IMMEDIATE_ACC, 8'h55, 11'h000, 7'h00, 8'h55, 1'b1},
    '{OP_READ_PAGE_REG_TO_ACC, 8'h00, 11'h000, 7'h05, 8'hAA, 1'b1},
    '{OP_OR_IMMEDIATE_ACC, 8'h50, 11'h000, 7'h00, 8'hFA, 1'b0},
    '{OP_STORE_ACC_TO_REG, 8'h00, 11'h000, 7'h7F, 8'hFA, 1'b0},
    '{OP_LONG_JUMP, 8'h00, 11'h7FF, 7'h00, 8'hFA, 1'b0},
    '{OP_WRITE_PAGE_REG_FROM_ACC, 8'h00, 11'h000, 7'h0F, 8'hFA, 1'b0},
    '{OP_LOAD_IMMEDIATE_ACC, 8'h00, 11'h000, 7'h00, 8'h00, 1'b0},
    '{OP_READ_PAGE_REG_TO_ACC, 8'h00, 11'h000, 7'h0F, 8'hFA, 1'b0},
    '{OP_LONG_CALL, 8'h00, 11'h123, 7'h00, 8'hFA, 1'b0},
    '{OP_READ_PAGE_REG_TO_ACC, 8'h00, 11'h000, 7'h04, 8'hFA, 1'b0},
    '{OP_NONE, 8'h00, 11'h000, 7'h00, 8'hFA, 1'b0}};
  instr_exec #(.STACK_DEPTH(8)) u_instr_exec (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
    .page_rdata_i(page_rdata_i), .page_raddr_o(page_raddr_o), .page_wr_o(page_wr_o),
    .reg_wr_o(reg_wr_o), .push_o(push_o), .acc_o(acc_o), .zero_o(zero_o), .pc_o(pc_o),
    .sp_o(sp_o), .stack_ovf_o(stack_ovf_o));
  page_reg_model u_page_reg_model (.mclk_i(mclk_i), .page_raddr_i(page_raddr_o),
    .page_wr_i(page_wr_o), .page_rdata_o(page_rdata_i));
  initial forever #12.5 mclk_i = ~mclk_i;
  // ==========================================================================
  // Compare, closing and issue tasks
  task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("Compares %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One word, then wait out any call stall under a bound
  task automatic issue(input op_t op, input logic [7:0] imm, input logic [10:0] adr,
                       input logic [6:0] ra);
    int n;
    @(negedge mclk_i);
    instr_i = '{op, imm, adr, ra};
    instr_valid_i = 1'b1;
    @(negedge mclk_i);
    instr_valid_i = 1'b0;
    for (n = 0; n < 8 && instr_ready_o !== 1'b1; n++)
      @(negedge mclk_i);
  endtask
  initial
  begin
    repeat (1000) @(posedge mclk_i);
    errors++;
    final_report();
  end
  initial
  begin
    repeat (16) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    chk_val({3'h0, acc_o}, 11'h000);
    chk_val({10'h000, zero_o}, 11'h000);
    chk_val({10'h000, stack_ovf_o}, 11'h000);
    chk_val(pc_o, 11'h000);
    exp_pc = 11'h000;
    foreach (rows[i])
    begin
      issue(rows[i].op, rows[i].imm, rows[i].adr, rows[i].ra);
      exp_pc = (rows[i].op inside {OP_LONG_JUMP, OP_LONG_CALL}) ? rows[i].adr : exp_pc + 11'h001;
      chk_val({3'h0, acc_o}, {3'h0, rows[i].acc});
      chk_val({10'h000, zero_o}, {10'h000, rows[i].z});
      chk_val(pc_o, exp_pc);
    end
    chk_val({7'h00, sp_o}, 11'h001);
    // Fill the stack, then one call too many: pointer holds, overflow sticks
    repeat (7) issue(OP_LONG_CALL, 8'h00, 11'h200, 7'h00);
    chk_val({7'h00, sp_o}, 11'h008);
    chk_val({10'h000, stack_ovf_o}, 11'h000);
    issue(OP_LONG_CALL, 8'h00, 11'h345, 7'h00);
    chk_val({7'h00, sp_o}, 11'h008);
    chk_val({10'h000, stack_ovf_o}, 11'h001);
    chk_val(pc_o, 11'h345);
    // Back-to-back words with no idle cycle between them
    @(negedge mclk_i);
    instr_valid_i = 1'b1;
    instr_i = '{OP_LOAD_IMMEDIATE_ACC, 8'h01, 11'h000, 7'h00};
    @(negedge mclk_i);
    instr_i = '{OP_OR_IMMEDIATE_ACC, 8'h80, 11'h000, 7'h00};
    @(negedge mclk_i);
    instr_valid_i = 1'b0;
    chk_val({3'h0, acc_o}, 11'h081);
    // Reset again in mid-run
    sys_rst_i = 1'b1;
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    chk_val(pc_o, 11'h000);
    chk_val({7'h00, sp_o}, 11'h000);
    chk_val({3'h0, acc_o}, 11'h000);
    chk_val({10'h000, zero_o}, 11'h000);
    chk_val({10'h000, stack_ovf_o}, 11'h000);
    // First word after the release is taken at once
    issue(OP_LOAD_IMMEDIATE_ACC, 8'h3C, 11'h000, 7'h00);
    chk_val({3'h0, acc_o}, 11'h03C);
    chk_val(pc_o, 11'h001);
    final_report();
  end
endmodule
`default_nettype wire
